//--- hw/xalu_pkg.sv
// package: constants, types and helpers shared by the extended alu datapath
package xalu_pkg;

    // ------------------------------------------------------------------
    // data widths
    // ------------------------------------------------------------------
    localparam int unsigned DW = 20;       // address-word width
    localparam int unsigned RW = 4;        // register number width

    // ------------------------------------------------------------------
    // operation and width codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_DEC  = 3'h0,
        OP_DECD = 3'h1,
        OP_INC  = 3'h2,
        OP_INCD = 3'h3,
        OP_INV  = 3'h4,
        OP_MOVE = 3'h5,
        OP_POP  = 3'h6,
        OP_BAD  = 3'h7
    } xalu_op_t;

    typedef enum logic [1:0] {
        WD_WORD = 2'h0,                    // no suffix selects this code
        WD_BYTE = 2'h1,
        WD_ADDR = 2'h2,
        WD_BAD  = 2'h3
    } xalu_width_t;

    // ------------------------------------------------------------------
    // apb map
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CMD      = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_RESULT   = 12'h008;
    localparam logic [11:0] ADDR_REG_BASE = 12'h040;
    localparam logic [11:0] ADDR_STK_BASE = 12'h100;

    // command word fields
    localparam int unsigned CMD_OP_LSB  = 0;
    localparam int unsigned CMD_WD_LSB  = 4;
    localparam int unsigned CMD_DST_LSB = 8;
    localparam int unsigned CMD_SRC_LSB = 12;
    localparam int unsigned CMD_CNT_LSB = 16;

    // status register fields
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_REF_BIT  = 1;
    localparam int unsigned ST_FLG_LSB  = 8;

    // ------------------------------------------------------------------
    // status word layout and special registers
    // ------------------------------------------------------------------
    localparam int unsigned SR_C = 0;
    localparam int unsigned SR_Z = 1;
    localparam int unsigned SR_N = 2;
    localparam int unsigned SR_V = 8;
    localparam logic [RW-1:0] REG_SP = 4'h1;
    localparam logic [RW-1:0] REG_SR = 4'h2;

    localparam logic [DW-1:0] K_ONE        = 20'h00001;
    localparam logic [DW-1:0] K_TWO        = 20'h00002;
    localparam logic [DW-1:0] SP_STEP_ADDR = 20'h00004;
    localparam logic [DW-1:0] SP_STEP_WORD = 20'h00002;

    // all-ones mask of the selected width
    function automatic logic [DW-1:0] width_mask(input xalu_width_t w);
        unique case (w)
            WD_BYTE: width_mask = 20'h000FF;
            WD_ADDR: width_mask = 20'hFFFFF;
            default: width_mask = 20'h0FFFF;
        endcase
    endfunction

    // sign bit position of the selected width
    function automatic logic [4:0] msb_idx(input xalu_width_t w);
        unique case (w)
            WD_BYTE: msb_idx = 5'h07;
            WD_ADDR: msb_idx = 5'h13;
            default: msb_idx = 5'h0F;
        endcase
    endfunction

endpackage

//--- hw/xalu_unit.sv
// combinational arithmetic unit for the single-operand extended instructions
module xalu_unit
    import xalu_pkg::*;
(
    input  wire xalu_op_t     op,
    input  wire xalu_width_t  wsel,
    input  wire logic [DW-1:0] dst_val,
    input  wire logic [DW-1:0] src_val,
    output logic [DW-1:0]     result,
    output logic              flag_n,
    output logic              flag_z,
    output logic              flag_c,
    output logic              flag_v
);

    // ------------------------------------------------------------------
    // result and flags
    // ------------------------------------------------------------------
    always_comb begin
        logic [DW-1:0] m;
        logic [4:0]    mi;
        logic [DW-1:0] a;
        logic [DW-1:0] k;
        logic [DW:0]   sum;
        m      = width_mask(wsel);
        mi     = msb_idx(wsel);
        a      = dst_val & m;
        k      = (op == OP_DECD || op == OP_INCD) ? K_TWO : K_ONE;
        sum    = {1'b0, a} + {1'b0, k};
        result = a;
        flag_c = 1'b0;
        flag_v = 1'b0;
        unique case (op)
            OP_DEC, OP_DECD: begin
                result = (a - k) & m;
                flag_c = (a >= k);
                flag_v = a[mi] & ~result[mi];
            end
            OP_INC, OP_INCD: begin
                result = sum[DW-1:0] & m;
                flag_c = sum[mi + 5'h01];
                flag_v = ~a[mi] & result[mi];
            end
            OP_INV: begin
                result = ~a & m;
                flag_c = (result != '0);
                flag_v = a[mi];
            end
            OP_MOVE: result = src_val & m;
            default: result = a;
        endcase
        flag_n = result[mi];
        flag_z = (result == '0);
    end

endmodule

//--- hw/xalu_regfile.sv
// processor register bank: one write port, two asynchronous read ports
module xalu_regfile
    import xalu_pkg::*;
#(
    parameter int NREG = 16
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          we,
    input  wire logic [RW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [RW-1:0] raddr_a,
    output logic [DW-1:0]      rdata_a,
    input  wire logic [RW-1:0] raddr_b,
    output logic [DW-1:0]      rdata_b
);

    logic [DW-1:0] regs [NREG];

    // ------------------------------------------------------------------
    // storage, cleared by reset so flags start defined
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NREG; i++) begin
                regs[i] <= '0;
            end
        end else if (we) begin
            regs[waddr] <= wdata;
        end
    end

    // reads see the stored value, not the one being written
    assign rdata_a = regs[raddr_a];
    assign rdata_b = regs[raddr_b];

endmodule

//--- hw/xalu_top.sv
// extended alu datapath with multi-register pop, reached over apb
//
// The APB register port and the address map were chosen for this implementation.
module xalu_top
    import xalu_pkg::*;
#(
    parameter int STK_AW = 6
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_EXEC   = 3'b001,
        ST_FLAGS  = 3'b010,
        ST_POP    = 3'b011,
        ST_POP_SP = 3'b100
    } xalu_state_t;

    xalu_state_t   state;
    xalu_op_t      op_q;
    xalu_width_t   wd_q;
    logic [RW-1:0] dst_q;
    logic [RW-1:0] src_q;
    logic [RW-1:0] cnt_q;
    logic [RW-1:0] idx_q;
    logic [DW-1:0] sp_q;
    logic [DW-1:0] result_q;
    logic [19:0]   cmd_q;
    logic          fl_n_q;
    logic          fl_z_q;
    logic          fl_c_q;
    logic          fl_v_q;
    logic          refused;

    logic [15:0]   stk [2**STK_AW];

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic              hit_cmd;
    logic              hit_status;
    logic              hit_result;
    logic              hit_reg;
    logic              hit_stk;
    logic              busy;
    logic              acc;
    logic              done;
    logic              cmd_ok;
    logic              err;
    logic [31:0]       rd_val;
    logic [RW-1:0]     reg_idx;
    logic [STK_AW-1:0] stk_idx;
    xalu_op_t          wr_op;
    xalu_width_t       wr_wd;

    assign busy       = (state != ST_IDLE);
    assign hit_cmd    = (paddr == ADDR_CMD);
    assign hit_status = (paddr == ADDR_STATUS);
    assign hit_result = (paddr == ADDR_RESULT);
    assign hit_reg    = (paddr[11:6] == ADDR_REG_BASE[11:6]);
    assign hit_stk    = (paddr[11:8] == ADDR_STK_BASE[11:8]);
    assign reg_idx    = paddr[RW+1:2];
    assign stk_idx    = paddr[STK_AW+1:2];
    assign wr_op      = xalu_op_t'(pwdata[CMD_OP_LSB +: 3]);
    assign wr_wd      = xalu_width_t'(pwdata[CMD_WD_LSB +: 2]);

    // first access cycle evaluates, second one completes
    assign acc  = psel & penable & ~pready;
    assign done = psel & penable & pready;

    // byte form of the pop does not exist
    assign cmd_ok = (wr_op != OP_BAD) && (wr_wd != WD_BAD)
                    && !(wr_op == OP_POP && wr_wd == WD_BYTE);

    // writes into live state are refused while a command runs
    always_comb begin
        err = !(hit_cmd | hit_status | hit_result | hit_reg | hit_stk);
        if (pwrite && busy && (hit_cmd || hit_reg || hit_stk)) begin
            err = 1'b1;
        end
        if (pwrite && hit_cmd && !cmd_ok) begin
            err = 1'b1;
        end
        if (!pwrite && hit_reg && busy) begin
            err = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // register file and arithmetic unit
    // ------------------------------------------------------------------
    logic          rf_we;
    logic [RW-1:0] rf_waddr;
    logic [DW-1:0] rf_wdata;
    logic [RW-1:0] rf_raddr_b;
    logic [DW-1:0] rf_rdata_a;
    logic [DW-1:0] rf_rdata_b;
    logic [DW-1:0] alu_res;
    logic          alu_n;
    logic          alu_z;
    logic          alu_c;
    logic          alu_v;
    logic [DW-1:0] sr_new;
    logic [DW-1:0] pop_val;
    logic [DW-1:0] sp_step;
    logic [STK_AW-1:0] pop_lo_idx;

    // port a serves the bus when idle, the destination otherwise
    always_comb begin
        unique case (state)
            ST_IDLE:  rf_raddr_b = REG_SP;
            ST_FLAGS: rf_raddr_b = REG_SR;
            default:  rf_raddr_b = src_q;
        endcase
    end

    xalu_regfile #(
        .NREG (16)
    ) u_regs (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (rf_we),
        .waddr   (rf_waddr),
        .wdata   (rf_wdata),
        .raddr_a (busy ? dst_q : reg_idx),
        .rdata_a (rf_rdata_a),
        .raddr_b (rf_raddr_b),
        .rdata_b (rf_rdata_b)
    );

    xalu_unit u_alu (
        .op      (op_q),
        .wsel    (wd_q),
        .dst_val (rf_rdata_a),
        .src_val (rf_rdata_b),
        .result  (alu_res),
        .flag_n  (alu_n),
        .flag_z  (alu_z),
        .flag_c  (alu_c),
        .flag_v  (alu_v)
    );

    // only the four arithmetic flags change, mode bits pass through
    always_comb begin
        sr_new       = rf_rdata_b;
        sr_new[SR_C] = fl_c_q;
        sr_new[SR_Z] = fl_z_q;
        sr_new[SR_N] = fl_n_q;
        sr_new[SR_V] = fl_v_q;
    end

    // ------------------------------------------------------------------
    // stack memory for the pop
    // ------------------------------------------------------------------
    assign pop_lo_idx = sp_q[STK_AW:1];

    // high word of an address-word sits above the low word
    always_comb begin
        if (wd_q == WD_ADDR) begin
            pop_val = {stk[STK_AW'(pop_lo_idx + 1'b1)][3:0], stk[pop_lo_idx]};
        end else begin
            pop_val = {4'h0, stk[pop_lo_idx]};
        end
    end

    assign sp_step = (wd_q == WD_ADDR) ? SP_STEP_ADDR : SP_STEP_WORD;

    // no reset on the array: it models plain ram
    always_ff @(posedge pclk) begin
        if (done && pwrite && hit_stk && !pslverr) begin
            stk[stk_idx] <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // register file write steering
    // ------------------------------------------------------------------
    always_comb begin
        rf_we    = 1'b0;
        rf_waddr = '0;
        rf_wdata = '0;
        unique case (state)
            ST_IDLE: begin
                if (done && pwrite && hit_reg && !pslverr) begin
                    rf_we    = 1'b1;
                    rf_waddr = reg_idx;
                    rf_wdata = pwdata[DW-1:0];
                end
            end
            ST_EXEC: begin
                rf_we    = 1'b1;
                rf_waddr = dst_q;
                rf_wdata = alu_res;
            end
            ST_FLAGS: begin
                rf_we    = 1'b1;
                rf_waddr = REG_SR;
                rf_wdata = sr_new;
            end
            ST_POP: begin
                rf_we    = 1'b1;
                rf_waddr = idx_q;
                rf_wdata = pop_val;
            end
            ST_POP_SP: begin
                rf_we    = 1'b1;
                rf_waddr = REG_SP;
                rf_wdata = sp_q;
            end
            default: rf_we = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            op_q  <= OP_DEC;
            wd_q  <= WD_WORD;
            dst_q <= '0;
            src_q <= '0;
            cnt_q <= '0;
            idx_q <= '0;
            sp_q  <= '0;
            cmd_q <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // one command write starts a whole instruction
                    if (done && pwrite && hit_cmd && !pslverr) begin
                        op_q  <= wr_op;
                        wd_q  <= wr_wd;
                        dst_q <= pwdata[CMD_DST_LSB +: RW];
                        src_q <= pwdata[CMD_SRC_LSB +: RW];
                        cnt_q <= pwdata[CMD_CNT_LSB +: RW];
                        idx_q <= RW'(pwdata[CMD_DST_LSB +: RW] - pwdata[CMD_CNT_LSB +: RW]);
                        sp_q  <= rf_rdata_b;
                        cmd_q <= pwdata[19:0];
                        state <= (wr_op == OP_POP) ? ST_POP : ST_EXEC;
                    end
                end
                ST_EXEC:  state <= (op_q == OP_MOVE) ? ST_IDLE : ST_FLAGS;
                ST_FLAGS: state <= ST_IDLE;
                ST_POP: begin
                    sp_q  <= sp_q + sp_step;
                    idx_q <= RW'(idx_q + 1'b1);
                    if (cnt_q == '0) begin
                        state <= ST_POP_SP;
                    end else begin
                        cnt_q <= RW'(cnt_q - 1'b1);
                    end
                end
                ST_POP_SP: state <= ST_IDLE;
                default:   state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // captured result of the last non-pop command, flags of the last arithmetic command
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= '0;
            fl_n_q   <= 1'b0;
            fl_z_q   <= 1'b0;
            fl_c_q   <= 1'b0;
            fl_v_q   <= 1'b0;
        end else if (state == ST_EXEC) begin
            result_q <= alu_res;
            if (op_q != OP_MOVE) begin
                fl_n_q <= alu_n;
                fl_z_q <= alu_z;
                fl_c_q <= alu_c;
                fl_v_q <= alu_v;
            end
        end
    end

    // ------------------------------------------------------------------
    // refused-command sticky flag, set wins over the clear
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused <= 1'b0;
        end else if (done && pwrite && hit_cmd && pslverr) begin
            refused <= 1'b1;
        end else if (done && pwrite && hit_status && pwdata[ST_REF_BIT]) begin
            refused <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        rd_val = '0;
        if (hit_cmd) begin
            rd_val = {12'h000, cmd_q};
        end else if (hit_status) begin
            rd_val[ST_BUSY_BIT]       = busy;
            rd_val[ST_REF_BIT]        = refused;
            rd_val[ST_FLG_LSB +: 4]   = {fl_n_q, fl_z_q, fl_c_q, fl_v_q};
        end else if (hit_result) begin
            rd_val = {12'h000, result_q};
        end else if (hit_reg) begin
            rd_val = {12'h000, rf_rdata_a};
        end else if (hit_stk) begin
            rd_val = {16'h0000, stk[stk_idx]};
        end
    end

    // ------------------------------------------------------------------
    // apb answer: one wait state, every output from a flop
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= acc;
            pslverr <= acc & err;
            prdata  <= (acc && !pwrite && !err) ? rd_val : 32'h00000000;
        end
    end

endmodule

//--- bench/xalu_props.sv
// checker: apb handshake and read data rules of the extended alu
module xalu_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------
    // handshake steps
    // ----------------------------------
    sequence s_setup; psel && !penable; endsequence
    sequence s_wait; psel && penable && !pready; endsequence
    // a read that was accepted, so its data must be clean
    logic rd_ok;
    assign rd_ok = pready && !pwrite && !pslverr;
    a_one_wait: assert property (s_setup ##1 s_wait |=> pready) else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_ready_access: assert property (pready |-> psel && penable) else $error("stray pready");
    a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad refusal");
    a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    a_bad_cmd: assert property (pready && pwrite && paddr == 12'h000 && pwdata[2:0] == 3'h7 |-> pslverr)
        else $error("bad op taken");
    a_reg_width: assert property (rd_ok && paddr[11:6] == 6'h01 |-> prdata[31:20] == 12'h0)
        else $error("reg too wide");
    a_stack_width: assert property (rd_ok && paddr[11:8] == 4'h1 |-> prdata[31:16] == 16'h0)
        else $error("stack too wide");
endmodule

bind xalu_top xalu_props i_xalu_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

//--- bench/xalu_apb_master.sv
// partner model: processor side apb master, one transfer at a time
module xalu_apb_master (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // request held until pready is sampled; only the bench watchdog ends a dead wait
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

//--- bench/xalu_top_tb.sv
// testbench: extended alu datapath driven over apb
module xalu_top_tb
    import xalu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv, sv;
    int          fail_count, comparisons;
    xalu_top i_xalu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    xalu_apb_master i_xalu_apb_master (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // the run needs well under 40000 cycles, so this only fires on a hang
    initial begin
        #(20 * 40000);
        fail_count++;
        finish_test();
    end
    // ----------------------------------
    // helpers
    // ----------------------------------
    task automatic finish_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_xalu_apb_master.xfer(1'b1, a, d, rv, err);
    endtask
    task automatic rd(input logic [11:0] a);
        i_xalu_apb_master.xfer(1'b0, a, 32'h0, rv, err);
    endtask
    function automatic logic [11:0] ra(input int i);
        return ADDR_REG_BASE + 12'(4 * i);
    endfunction
    // start a command, then poll busy with a bounded count
    task automatic cmd(input logic [2:0] op, input logic [1:0] w, input logic [3:0] d, s, c);
        wr(ADDR_CMD, {12'h0, c, s, d, 2'h0, w, 1'h0, op});
        for (int i = 0; i < 40; i++) begin
            rd(ADDR_STATUS);
            if (rv[ST_BUSY_BIT] === 1'b0) break;
        end
    endtask
    // ----------------------------------
    // scenarios
    // ----------------------------------
    // boundary operands of every width and of the five arithmetic ops (dec, decd, inc, incd, inv); upper garbage shows zero extension
    task automatic t_arith();
        logic [19:0] m, h, a, r;
        int s;
        logic n, z, c, o;
        for (int w = 0; w < 3; w++)
            for (int op = 0; op < 5; op++)
                for (int k = 0; k < 8; k++) begin
                    m = (w == 1) ? 20'h000FF : (w == 2) ? 20'hFFFFF : 20'h0FFFF;
                    s = (w == 1) ? 7 : (w == 2) ? 19 : 15;
                    h = m >> 1;
                    a = (k < 3) ? 20'(k) : (k < 6) ? h + 20'(k) - 20'h4 : m + 20'(k) - 20'h7;
                    wr(ra(4), 32'(a | (~m & 20'hA5A5A)));
                    wr(ra(2), 32'h38);
                    cmd(3'(op), 2'(w), 4'h4, 4'h0, 4'h0);
                    r = (op == 4) ? ~a : (op < 2) ? a - 20'(op + 1) : a + 20'(op - 1);
                    r = r & m;
                    n = r[s];
                    z = (r == 20'h0);
                    c = (op == 4) ? !z : (op < 2) ? a > 20'(op) : a >= m - 20'(op - 2);
                    o = (op == 4) ? a[s] : (op < 2) ? a[s] & !r[s] : (a <= h) && (a >= h - 20'(op - 2));
                    rd(ra(4));
                    chk(rv, 32'(r));
                    rd(ADDR_STATUS);
                    chk(32'(rv[11:8]), 32'({n, z, c, o}));
                    rd(ra(2));
                    chk(rv, 32'({o, 2'h0, 3'h7, n, z, c}));
                end
    endtask
    task automatic t_move();
        logic [31:0] st;
        wr(ra(5), 32'hF1234);
        rd(ra(2));
        sv = rv;
        rd(ADDR_STATUS);
        st = rv;
        cmd(OP_MOVE, WD_ADDR, 4'h6, 4'h5, 4'h0);
        rd(ra(6));
        chk(rv, 32'hF1234);
        rd(ra(5));
        chk(rv, 32'hF1234);
        rd(ra(2));
        chk(rv, sv);
        rd(ADDR_STATUS);
        chk(rv, st);
        rd(ADDR_RESULT);
        chk(rv, 32'hF1234);
        rd(ADDR_CMD);
        chk(rv, 32'h05625);
        cmd(OP_MOVE, WD_WORD, 4'h7, 4'h5, 4'h0);
        rd(ra(7));
        chk(rv, 32'h01234);
    endtask
    // address-word pop, wrapping word pop, then a pop into the status word
    task automatic t_pop();
        for (int k = 0; k < 12; k++) wr(ADDR_STK_BASE + 12'(4 * k), 32'hA5C0 + 32'(k));
        wr(ra(1), 32'h0);
        cmd(OP_POP, WD_ADDR, 4'h9, 4'h0, 4'h2);
        for (int j = 0; j < 3; j++) begin
            rd(ra(7 + j));
            chk(rv, 32'({4'(2 * j + 1), 16'hA5C0 + 16'(2 * j)}));
        end
        rd(ra(1));
        chk(rv, 32'h0000C);
        wr(ra(15), 32'hFFFFF);
        cmd(OP_POP, WD_WORD, 4'h0, 4'h0, 4'h1);
        rd(ra(15));
        chk(rv, 32'hA5C6);
        rd(ra(0));
        chk(rv, 32'hA5C7);
        cmd(OP_POP, WD_WORD, 4'h2, 4'h0, 4'h0);
        rd(ra(2));
        chk(rv, 32'hA5C8);
        rd(ra(1));
        chk(rv, 32'h00012);
    endtask
    // unknown op, unknown width, byte pop and a hole in the map are refused
    task automatic t_refuse();
        logic [31:0] bad [3] = '{32'h7, 32'h30, 32'h16};
        foreach (bad[i]) begin
            wr(ADDR_CMD, bad[i]);
            chk(32'(err), 32'h1);
        end
        rd(12'h00C);
        chk(32'(err), 32'h1);
        rd(ADDR_STATUS);
        chk(32'(rv[ST_REF_BIT]), 32'h1);
        wr(ADDR_STATUS, 32'h2);
        rd(ADDR_STATUS);
        chk(32'(rv[ST_REF_BIT]), 32'h0);
    endtask
    initial begin
        fail_count = 0;
        comparisons = 0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_arith();
        t_move();
        t_pop();
        t_refuse();
        finish_test();
    end
endmodule
